// ### pkg/can_wake_pkg.sv
// constants of the wake and send packer
package can_wake_pkg;
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          TICK_NS         = 1_000_000;
   localparam int          TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
   localparam int          WAKE_TIMEOUT_MIN = 1;
   localparam logic [15:0] WAKE_TIMEOUT_MS = 16'(WAKE_TIMEOUT_MIN * 60_000);
   localparam int          REMOTE_MIN_S    = 1;
   localparam logic [10:0] REMOTE_MIN_MS   = 11'(REMOTE_MIN_S * 1000);
   localparam logic [15:0] FOLLOW_MS_RST   = 16'h1388;
   // bus interface firmware must be newer than 01.04.00
   localparam logic [23:0] FW_MIN          = 24'h01_0400;

   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_FIRST_ID    = 8'h04;
   localparam logic [7:0]  OFS_COUNTER     = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0C;
   localparam logic [7:0]  OFS_MASK        = 8'h10;
   localparam logic [7:0]  OFS_ERR_COUNT   = 8'h14;
   localparam logic [7:0]  OFS_STATE       = 8'h18;
   localparam logic [7:0]  OFS_SIGNALS     = 8'h1C;
   localparam logic [7:0]  OFS_TIMEOUT     = 8'h20;
   localparam logic [7:0]  OFS_FOLLOW      = 8'h24;
   localparam logic [7:0]  OFS_SEND_COUNT  = 8'h28;
   localparam logic [7:0]  OFS_TABLE       = 8'h40;

   localparam int          C_WAKE_EN   = 0;
   localparam int          C_COND_MODE = 1;
   localparam int          C_SEND_EN   = 2;
   localparam int          C_CNT_EN    = 3;
   localparam int          C_CNT_BE    = 4;
   localparam int          C_AUTO      = 5;
   localparam int          C_EXT_ID    = 6;
   localparam int          C_RATE_LSB  = 8;
   localparam logic [15:0] CTRL_RST     = 16'h0429;
   localparam logic [28:0] FIRST_ID_RST = 29'h0000_0100;
   localparam logic [5:0]  CNT_START_RST = 6'h00;
   localparam logic [5:0]  CNT_WIDTH_RST = 6'h10;

   localparam int          S_WOKE     = 0;
   localparam int          S_SHUTDOWN = 1;
   localparam int          S_TX_ERR   = 2;
   localparam int          S_BUF_FULL = 3;
   localparam int          S_SENT     = 4;
   localparam int          NUM_STATUS = 5;

   // table entry fields
   localparam int          T_START_LSB = 0;
   localparam int          T_COUNT_LSB = 6;
   localparam int          T_BE        = 12;
   localparam int          T_SLOT_LSB  = 13;
   localparam int          NUM_SIG     = 8;
   localparam int          FRAME_BITS  = 64;
   localparam logic [3:0]  FRAME_DLC   = 4'h8;

   // send period in ms per rate code 0.5/1/2/5/10/20/50/100 Hz
   localparam logic [10:0] RATE_PERIOD_MS [8] = '{11'h7D0, 11'h3E8, 11'h1F4, 11'h0C8,
                                                  11'h064, 11'h032, 11'h014, 11'h00A};
endpackage : can_wake_pkg

// ### hw/sig_table_mem.sv
// signal table, registered read port
`timescale 1ns/100ps
module sig_table_mem (
   input  wire logic        mclk,
   input  wire logic        we,
   input  wire logic [3:0]  waddr,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  raddr,
   output logic      [31:0] rdata
);
   logic [31:0] mem [16];

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : sig_table_mem

// ### hw/can_wake_and_send_packer.sv
// wake control and periodic frame packer
`timescale 1ns/100ps
// How it works
// (RULE1) bus activity with wake enabled switches the logger power on
// (RULE2) without off condition, remote must rise before timeout, else power off
// (RULE3) remote mode: run while remote high, then follow-up, postprocess, off
// (RULE4) off-condition mode ignores timeout and runs while condition false
// (RULE5) remote high over one second starts follow-up at its falling edge
// (RULE6) all signals go out at one common rate from eight choices
// (RULE7) transmit rate at or above source acquisition rate flags buffer full
// (RULE8) auto identifiers start at a first identifier, reset value 100 hex
// (RULE9) auto mode packs signals into successive frames, one id each
// (RULE10) optional send counter counts cycles, placed at start bit with width
// (RULE11) send counter written little or big endian forward
// (RULE12) auto mode puts send counter in the first frame
// (RULE13) standard 11-bit and extended 29-bit identifiers both supported
// (RULE14) outside auto mode each signal placed at its start bit with its bit count
// (RULE15) each signal written in its own byte order
// (RULE16) unacknowledged frames flag a transmit error and are counted
// (RULE17) errors never stop frame output
// (RULE18) one frame port only, enabled only with new enough interface firmware
// (RULE19) send counter wraps to zero at its width maximum
module can_wake_and_send_packer #(
   parameter int TICK_CYCLES = can_wake_pkg::TICK_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic             waitrequest,
   output logic      [31:0] readdata,
   output logic             irq,
   input  wire logic        bus_activity,
   input  wire logic        remote_line,
   input  wire logic        off_condition,
   input  wire logic        postproc_done,
   output logic             power_hold,
   output logic             postproc_start,
   input  wire logic [23:0] can_fw_version,
   output logic      [2:0]  value_index,
   input  wire logic [31:0] value_data,
   output logic             tx_valid,
   output logic      [28:0] tx_id,
   output logic             tx_ext,
   output logic      [3:0]  tx_dlc,
   output logic      [63:0] tx_data,
   input  wire logic        tx_ready,
   input  wire logic        tx_done,
   input  wire logic        tx_ack_ok
);
   typedef enum logic [2:0] {P_OFF, P_WAIT, P_RUN_REM, P_RUN_COND, P_FOLLOW, P_POST} pwr_t;
   typedef enum logic [2:0] {Q_IDLE, Q_ID, Q_IDW, Q_RD, Q_CFG, Q_SEND, Q_ADV, Q_FIN} seq_t;
   typedef struct packed {
      pwr_t        pwr;
      logic        power_hold;
      logic        post_start;
      logic [17:0] tick_cnt;
      logic        tick;
      logic [15:0] ms_cnt;
      logic [10:0] hi_ms;
      logic        remote_d;
      logic [15:0] ctrl;
      logic [28:0] first_id;
      logic [5:0]  cnt_start;
      logic [5:0]  cnt_width;
      logic [3:0]  sig_count;
      logic [2:0]  acq_code;
      logic [15:0] timeout_ms;
      logic [15:0] follow_ms;
      logic [4:0]  status;
      logic [4:0]  mask;
      logic [15:0] err_cnt;
      logic        waitreq;
      logic [31:0] rdata;
      logic        irq;
      seq_t        seq;
      logic [10:0] rate_cnt;
      logic [3:0]  slot;
      logic [3:0]  sig;
      logic [3:0]  frame_no;
      logic [6:0]  cursor;
      logic        has;
      logic [63:0] payload;
      logic [28:0] id;
      logic [31:0] send_cnt;
      logic [2:0]  vidx;
      logic        tx_valid;
      logic [28:0] tx_id;
      logic [63:0] tx_data;
   } st_t;

   st_t         r;
   st_t         next_r;
   logic        mem_we;
   logic [3:0]  mem_raddr;
   logic [31:0] mem_rdata;

   // big endian reverses the value's bytes
   function automatic logic [63:0] place(input logic [63:0] p, input logic [31:0] v,
                                         input logic [6:0] start, input logic [5:0] cnt,
                                         input logic be);
      logic [63:0] res;
      logic [6:0]  pos;
      int          nb;
      int          k;
      res = p;
      nb  = (int'(cnt) + 7) / 8;
      for (int i = 0; i < 32; i++) begin
         k   = be ? ((nb - 1 - i / 8) * 8 + i % 8) : i;
         pos = start + 7'(k);
         if (i < int'(cnt) && pos < 7'(can_wake_pkg::FRAME_BITS)) begin
            res[pos[5:0]] = v[i];
         end
      end
      return res;
   endfunction : place

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction : merge

   assign mem_we    = write && !r.waitreq && address >= can_wake_pkg::OFS_TABLE;
   assign mem_raddr = (r.seq == Q_ID) ? {1'b1, r.slot[2:0]} : {1'b0, r.sig[2:0]};

   sig_table_mem u_table (
      .mclk  (mclk),
      .we    (mem_we),
      .waddr (address[5:2]),
      .wdata (writedata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   always_comb begin
      logic        fw_ok;
      logic        auto_mode;
      logic        send_go;
      logic        rem_fall;
      logic [31:0] wd;
      logic [31:0] cnt_mask;
      logic [4:0]  ev;
      logic [5:0]  cfg_cnt;
      logic [6:0]  cfg_start;
      logic [2:0]  rate;
      fw_ok     = can_fw_version > can_wake_pkg::FW_MIN; // RULE18
      auto_mode = r.ctrl[can_wake_pkg::C_AUTO];
      rate      = r.ctrl[can_wake_pkg::C_RATE_LSB +: 3];
      rem_fall  = r.remote_d && !remote_line;
      send_go   = 1'b0;
      wd        = '0;
      ev        = '0;
      cnt_mask  = (r.cnt_width >= 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << r.cnt_width) - 1);
      cfg_cnt   = (mem_rdata[can_wake_pkg::T_COUNT_LSB +: 6] > 6'h20) ? 6'h20
                : mem_rdata[can_wake_pkg::T_COUNT_LSB +: 6];
      cfg_start = {1'b0, mem_rdata[can_wake_pkg::T_START_LSB +: 6]};
      next_r    = r;
      next_r.post_start = 1'b0;
      next_r.remote_d   = remote_line;

      // millisecond enable
      next_r.tick = 1'b0;
      if (r.tick_cnt == 18'(TICK_CYCLES - 1)) begin
         next_r.tick_cnt = '0;
         next_r.tick     = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 18'h0_0001;
      end

      unique case (r.pwr)
         P_OFF: begin
            if (r.ctrl[can_wake_pkg::C_WAKE_EN] && bus_activity) begin // RULE1
               next_r.power_hold = 1'b1;
               next_r.ms_cnt     = '0;
               next_r.hi_ms      = '0;
               ev[can_wake_pkg::S_WOKE] = 1'b1;
               next_r.pwr = r.ctrl[can_wake_pkg::C_COND_MODE] ? P_RUN_COND : P_WAIT;
            end
         end
         P_WAIT: begin
            if (remote_line) begin // RULE2
               next_r.pwr = P_RUN_REM;
            end else if (r.ms_cnt >= r.timeout_ms) begin // RULE2
               next_r.pwr        = P_OFF;
               next_r.power_hold = 1'b0;
               ev[can_wake_pkg::S_SHUTDOWN] = 1'b1;
            end else if (r.tick) begin
               next_r.ms_cnt = r.ms_cnt + 16'h0001;
            end
         end
         P_RUN_REM: begin
            if (!remote_line) begin // RULE3
               next_r.pwr    = P_FOLLOW;
               next_r.ms_cnt = '0;
            end
         end
         P_RUN_COND: begin
            if (remote_line && r.tick && r.hi_ms != 11'h7FF) begin
               next_r.hi_ms = r.hi_ms + 11'h001;
            end
            if (!remote_line) begin
               next_r.hi_ms = '0;
            end
            if (off_condition || (rem_fall && r.hi_ms > can_wake_pkg::REMOTE_MIN_MS)) begin // RULE4 RULE5
               next_r.pwr    = P_FOLLOW;
               next_r.ms_cnt = '0;
            end
         end
         P_FOLLOW: begin
            if (r.ms_cnt >= r.follow_ms) begin // RULE3
               next_r.pwr        = P_POST;
               next_r.post_start = 1'b1;
            end else if (r.tick) begin
               next_r.ms_cnt = r.ms_cnt + 16'h0001;
            end
         end
         P_POST: begin
            if (postproc_done) begin // RULE3 RULE5
               next_r.pwr        = P_OFF;
               next_r.power_hold = 1'b0;
               ev[can_wake_pkg::S_SHUTDOWN] = 1'b1;
            end
         end
         default: next_r.pwr = P_OFF;
      endcase

      // common send rate
      if (r.tick) begin
         if (r.rate_cnt >= can_wake_pkg::RATE_PERIOD_MS[rate] - 11'h001) begin // RULE6
            next_r.rate_cnt = '0;
            send_go = r.power_hold && r.ctrl[can_wake_pkg::C_SEND_EN] && fw_ok; // RULE18
         end else begin
            next_r.rate_cnt = r.rate_cnt + 11'h001;
         end
      end

      // frames go out whatever the error history
      unique case (r.seq)
         Q_IDLE: begin
            if (send_go) begin // RULE6 RULE17
               ev[can_wake_pkg::S_BUF_FULL] = rate >= r.acq_code; // RULE7
               next_r.slot     = '0;
               next_r.sig      = '0;
               next_r.frame_no = '0;
               next_r.payload  = '0;
               next_r.has      = r.ctrl[can_wake_pkg::C_CNT_EN];
               next_r.cursor   = r.ctrl[can_wake_pkg::C_CNT_EN]
                               ? 7'(r.cnt_start) + 7'(r.cnt_width) : 7'h00;
               if (r.ctrl[can_wake_pkg::C_CNT_EN]) begin // RULE10 RULE12
                  next_r.payload = place(64'h0, r.send_cnt, 7'(r.cnt_start), r.cnt_width,
                                         r.ctrl[can_wake_pkg::C_CNT_BE]); // RULE11
               end
               next_r.seq = auto_mode ? Q_RD : Q_ID;
            end
         end
         Q_ID:  next_r.seq = Q_IDW;
         Q_IDW: begin
            next_r.id  = mem_rdata[28:0];
            next_r.sig = '0;
            next_r.seq = Q_RD;
         end
         Q_RD: begin
            next_r.vidx = r.sig[2:0];
            if (r.sig >= r.sig_count) begin
               next_r.seq = r.has ? Q_SEND : Q_ADV;
            end else begin
               next_r.seq = Q_CFG;
            end
         end
         Q_CFG: begin
            next_r.seq = Q_RD;
            if (auto_mode) begin
               if (r.has && 8'(r.cursor) + 8'(cfg_cnt) > 8'(can_wake_pkg::FRAME_BITS)) begin
                  next_r.seq = Q_SEND; // RULE9
               end else begin
                  next_r.payload = place(r.payload, value_data, r.cursor, cfg_cnt,
                                         mem_rdata[can_wake_pkg::T_BE]); // RULE9 RULE15
                  next_r.cursor  = r.cursor + 7'(cfg_cnt);
                  next_r.has     = 1'b1;
                  next_r.sig     = r.sig + 4'h1;
               end
            end else begin
               if (mem_rdata[can_wake_pkg::T_SLOT_LSB +: 3] == r.slot[2:0]) begin
                  next_r.payload = place(r.payload, value_data, cfg_start, cfg_cnt,
                                         mem_rdata[can_wake_pkg::T_BE]); // RULE14 RULE15
                  next_r.has     = 1'b1;
               end
               next_r.sig = r.sig + 4'h1;
            end
         end
         Q_SEND: begin
            if (!r.tx_valid) begin
               next_r.tx_valid = 1'b1;
               next_r.tx_data  = r.payload;
               next_r.tx_id    = auto_mode ? r.first_id + 29'(r.frame_no) : r.id; // RULE8 RULE9
               if (!r.ctrl[can_wake_pkg::C_EXT_ID]) begin
                  next_r.tx_id[28:11] = '0; // RULE13
               end
            end else if (tx_ready) begin
               next_r.tx_valid = 1'b0;
               next_r.payload  = '0;
               next_r.has      = 1'b0;
               next_r.cursor   = '0;
               next_r.frame_no = r.frame_no + 4'h1;
               ev[can_wake_pkg::S_SENT] = 1'b1;
               next_r.seq = auto_mode ? Q_RD : Q_ADV;
            end
         end
         Q_ADV: begin
            next_r.slot = r.slot + 4'h1;
            next_r.seq  = (auto_mode || r.slot == 4'(can_wake_pkg::NUM_SIG - 1)) ? Q_FIN : Q_ID;
         end
         Q_FIN: begin
            if (r.ctrl[can_wake_pkg::C_CNT_EN]) begin
               next_r.send_cnt = (r.send_cnt + 32'h0000_0001) & cnt_mask; // RULE10 RULE19
            end
            next_r.seq = Q_IDLE;
         end
         default: next_r.seq = Q_IDLE;
      endcase

      if (tx_done && !tx_ack_ok) begin // RULE16
         ev[can_wake_pkg::S_TX_ERR] = 1'b1;
         if (r.err_cnt != 16'hFFFF) begin
            next_r.err_cnt = r.err_cnt + 16'h0001;
         end
      end

      // one wait cycle per access
      next_r.waitreq = 1'b1;
      if ((read || write) && r.waitreq) begin
         next_r.waitreq = 1'b0;
         unique case (address & 8'hFC)
            can_wake_pkg::OFS_CTRL:       next_r.rdata = {16'h0000, r.ctrl};
            can_wake_pkg::OFS_FIRST_ID:   next_r.rdata = {3'h0, r.first_id};
            can_wake_pkg::OFS_COUNTER:    next_r.rdata = {18'h0, r.cnt_width, 2'h0, r.cnt_start};
            can_wake_pkg::OFS_STATUS:     next_r.rdata = {27'h0, r.status};
            can_wake_pkg::OFS_MASK:       next_r.rdata = {27'h0, r.mask};
            can_wake_pkg::OFS_ERR_COUNT:  next_r.rdata = {16'h0000, r.err_cnt};
            can_wake_pkg::OFS_STATE:      next_r.rdata = {20'h0, 1'b0, r.seq, 3'h0,
                                                          r.power_hold, 1'b0, r.pwr};
            can_wake_pkg::OFS_SIGNALS:    next_r.rdata = {21'h0, r.acq_code, 4'h0, r.sig_count};
            can_wake_pkg::OFS_TIMEOUT:    next_r.rdata = {16'h0000, r.timeout_ms};
            can_wake_pkg::OFS_FOLLOW:     next_r.rdata = {16'h0000, r.follow_ms};
            can_wake_pkg::OFS_SEND_COUNT: next_r.rdata = r.send_cnt;
            default:                      next_r.rdata = '0;
         endcase
      end
      if (write && !r.waitreq) begin
         unique case (address & 8'hFC)
            can_wake_pkg::OFS_CTRL: begin
               wd = merge({16'h0000, r.ctrl}, writedata, byteenable);
               next_r.ctrl = wd[15:0];
            end
            can_wake_pkg::OFS_FIRST_ID: begin
               wd = merge({3'h0, r.first_id}, writedata, byteenable);
               next_r.first_id = wd[28:0];
            end
            can_wake_pkg::OFS_COUNTER: begin
               wd = merge({18'h0, r.cnt_width, 2'h0, r.cnt_start}, writedata, byteenable);
               next_r.cnt_start = wd[5:0];
               next_r.cnt_width = wd[13:8];
            end
            can_wake_pkg::OFS_STATUS: begin
               wd = merge(32'h0, writedata, byteenable);
               next_r.status = r.status & ~wd[4:0];
            end
            can_wake_pkg::OFS_MASK: begin
               wd = merge({27'h0, r.mask}, writedata, byteenable);
               next_r.mask = wd[4:0];
            end
            can_wake_pkg::OFS_SIGNALS: begin
               wd = merge({21'h0, r.acq_code, 4'h0, r.sig_count}, writedata, byteenable);
               next_r.sig_count = (wd[3:0] > 4'(can_wake_pkg::NUM_SIG))
                                ? 4'(can_wake_pkg::NUM_SIG) : wd[3:0];
               next_r.acq_code  = wd[10:8];
            end
            can_wake_pkg::OFS_TIMEOUT: begin
               wd = merge({16'h0000, r.timeout_ms}, writedata, byteenable);
               next_r.timeout_ms = wd[15:0];
            end
            can_wake_pkg::OFS_FOLLOW: begin
               wd = merge({16'h0000, r.follow_ms}, writedata, byteenable);
               next_r.follow_ms = wd[15:0];
            end
            default: wd = '0;
         endcase
      end else begin
         wd = '0;
      end
      // a new event beats a clear in the same cycle
      next_r.status = next_r.status | ev;
      next_r.irq    = |(next_r.status & next_r.mask);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r            <= '0;
         r.pwr        <= P_OFF;
         r.seq        <= Q_IDLE;
         r.waitreq    <= 1'b1;
         r.ctrl       <= can_wake_pkg::CTRL_RST;
         r.first_id   <= can_wake_pkg::FIRST_ID_RST;
         r.cnt_start  <= can_wake_pkg::CNT_START_RST;
         r.cnt_width  <= can_wake_pkg::CNT_WIDTH_RST;
         r.sig_count  <= 4'(can_wake_pkg::NUM_SIG);
         r.acq_code   <= 3'h7;
         r.timeout_ms <= can_wake_pkg::WAKE_TIMEOUT_MS;
         r.follow_ms  <= can_wake_pkg::FOLLOW_MS_RST;
      end else begin
         r <= next_r;
      end
   end

   assign waitrequest    = r.waitreq;
   assign readdata       = r.rdata;
   assign irq            = r.irq;
   assign power_hold     = r.power_hold;
   assign postproc_start = r.post_start;
   assign value_index    = r.vidx;
   assign tx_valid       = r.tx_valid;
   assign tx_id          = r.tx_id;
   assign tx_ext         = r.ctrl[can_wake_pkg::C_EXT_ID];
   assign tx_dlc         = can_wake_pkg::FRAME_DLC;
   assign tx_data        = r.tx_data;
endmodule : can_wake_and_send_packer

// ### sim/can_wake_and_send_packer_chk.sv
// packer port checks
`timescale 1ns/100ps
module can_wake_and_send_packer_chk (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        read,
   input wire logic        write,
   input wire logic        waitrequest,
   input wire logic        postproc_start,
   input wire logic [23:0] can_fw_version,
   input wire logic        tx_valid,
   input wire logic [28:0] tx_id,
   input wire logic        tx_ext,
   input wire logic [3:0]  tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic        tx_ready
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_ans; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("bus answer");
   property p_one; !waitrequest |=> waitrequest; endproperty
   a_one: assert property (p_one) else $error("wait low");
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data); endproperty
   a_hold: assert property (p_hold) else $error("frame moved");
   property p_drop; tx_valid && tx_ready |=> !tx_valid; endproperty
   a_drop: assert property (p_drop) else $error("frame held");
   property p_std; tx_valid && !tx_ext |-> tx_id[28:11] == 18'h0_0000; endproperty
   a_std: assert property (p_std) else $error("std id");
   property p_dlc; tx_valid |-> tx_dlc == can_wake_pkg::FRAME_DLC; endproperty
   a_dlc: assert property (p_dlc) else $error("dlc");
   property p_fw; can_fw_version <= can_wake_pkg::FW_MIN |-> !$rose(tx_valid); endproperty
   a_fw: assert property (p_fw) else $error("old firmware");
   property p_pp; $rose(postproc_start) |=> $fell(postproc_start); endproperty
   a_pp: assert property (p_pp) else $error("pp pulse");
endmodule : can_wake_and_send_packer_chk
bind can_wake_and_send_packer can_wake_and_send_packer_chk can_wake_and_send_packer_chk_inst (
   .mclk, .rst, .read, .write, .waitrequest, .postproc_start, .can_fw_version,
   .tx_valid, .tx_id, .tx_ext, .tx_dlc, .tx_data, .tx_ready);

// ### sim/can_frame_sink.sv
// frame controller model
`timescale 1ns/100ps
module can_frame_sink (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        tx_valid,
   input  wire logic [28:0] tx_id,
   input  wire logic [63:0] tx_data,
   input  wire logic        slow,
   input  wire logic        ack,
   output logic             tx_ready,
   output logic             tx_done,
   output logic             tx_ack_ok
);
   logic [7:0]  nf;
   logic [28:0] lid;
   logic [63:0] ldat;
   logic [2:0]  w;
   logic [1:0]  d;
   logic        a;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {tx_ready, tx_done, tx_ack_ok, nf, lid, ldat, w, d, a} <= '0;
      end else begin
         tx_ready <= 1'b0;
         tx_done <= d[0];
         tx_ack_ok <= d[0] ? a : ~tx_ack_ok;
         d <= {1'b0, d[1]};
         if (tx_valid && tx_ready) begin
            {nf, lid, ldat, a, w, d} <= {nf + 8'h01, tx_id, tx_data, ack, 3'h0, 2'b10};
         end else if (tx_valid) begin
            w <= w + 3'h1;
            tx_ready <= !slow || w == 3'h3;
         end
      end
   end
endmodule : can_frame_sink

// ### sim/can_wake_and_send_packer_tb_top.sv
// packer testbench
`timescale 1ns/100ps
module can_wake_and_send_packer_tb_top;
   logic        mclk, rst, read, write, waitrequest, irq, bus_activity, remote_line;
   logic        off_condition, postproc_done, power_hold, postproc_start, tx_valid;
   logic        tx_ext, tx_ready, tx_done, tx_ack_ok, slow, ack;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, value_data, q;
   logic [23:0] can_fw_version;
   logic [2:0]  value_index;
   logic [28:0] tx_id;
   logic [3:0]  tx_dlc;
   logic [63:0] tx_data;
   logic [15:0] c1;
   int          errors = 0, n_tests = 0, cyc;
   assign value_data = 32'h0000_00A0 + 32'(value_index);
   can_wake_and_send_packer #(.TICK_CYCLES(20)) can_wake_and_send_packer_inst (
      .mclk, .rst, .address, .read, .write, .writedata, .byteenable(4'hF), .waitrequest,
      .readdata, .irq, .bus_activity, .remote_line, .off_condition, .postproc_done,
      .power_hold, .postproc_start, .can_fw_version, .value_index, .value_data, .tx_valid,
      .tx_id, .tx_ext, .tx_dlc, .tx_data, .tx_ready, .tx_done, .tx_ack_ok);
   can_frame_sink sink (.mclk, .rst, .tx_valid, .tx_id, .tx_data, .slow,
      .ack, .tx_ready, .tx_done, .tx_ack_ok);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task end_sim;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] dt);
      int i;
      @(posedge mclk);
      {address, read, write, writedata} <= {a, !w, w, dt};
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      {read, write} <= 2'b00;
      if (i == 50) begin
         chk(1, 0);
         end_sim;
      end
   endtask : rw
   function logic sg(input int s);
      return s == 0 ? power_hold : s == 1 ? postproc_start : irq;
   endfunction : sg
   task automatic wt(input int s, input logic v, input int n);
      int i;
      for (i = 0; i < n && sg(s) !== v; i++) @(posedge mclk);
      chk(sg(s), v);
      if (i == n) end_sim;
   endtask : wt
   task automatic wf(input logic [7:0] k);
      int i;
      for (i = 0; i < 1000 && sink.nf !== k; i++) @(posedge mclk);
      chk(sink.nf, k);
      if (i == 1000) end_sim;
      cyc = i;
   endtask : wf
   task wake;
      bus_activity <= 1'b1;
      @(posedge mclk);
      bus_activity <= 1'b0;
      wt(0, 1, 10);
   endtask : wake
   task t_regs;
      rw(0, 8'h00, 0); chk(q, 32'h0000_0429);
      rw(0, 8'h04, 0); chk(q, 32'h0000_0100);
      rw(0, 8'h08, 0); chk(q, 32'h0000_1000);
      rw(0, 8'h3C, 0); chk(q, 32'h0000_0000);
   endtask : t_regs
   task t_wake;
      rw(1, 8'h20, 5); rw(1, 8'h24, 3); rw(1, 8'h10, 1);
      wake; wt(2, 1, 10);
      rw(1, 8'h0C, 1); wt(2, 0, 5);
      repeat (60) @(posedge mclk);
      chk(power_hold, 1);
      wt(0, 0, 150);
      rw(0, 8'h0C, 0); chk(q[1:0], 2'b10); chk(irq, 0);
   endtask : t_wake
   task t_remote;
      wake; remote_line <= 1'b1;
      repeat (300) @(posedge mclk);
      chk(power_hold, 1);
      remote_line <= 1'b0;
      wt(1, 1, 120); postproc_done <= 1'b1;
      wt(0, 0, 20); postproc_done <= 1'b0;
   endtask : t_remote
   task t_cond;
      rw(1, 8'h00, 32'h0000_042B); wake;
      repeat (300) @(posedge mclk);
      chk(power_hold, 1); remote_line <= 1'b1;
      repeat (20_200) @(posedge mclk);
      remote_line <= 1'b0;
      wt(1, 1, 120); postproc_done <= 1'b1;
      wt(0, 0, 20); postproc_done <= 1'b0;
   endtask : t_cond
   task t_send;
      rw(1, 8'h40, 32'h0000_0410); rw(1, 8'h44, 32'h0000_0420); rw(1, 8'h1C, 32'h0000_0702);
      rw(1, 8'h00, 32'h0000_062D); wake; remote_line <= 1'b1;
      repeat (900) @(posedge mclk);
      chk(sink.nf, 0); can_fw_version <= 24'h01_0401;
      wf(1); chk(sink.lid, 29'h100);
      chk(sink.ldat[63:16], 48'h0000_00A1_00A0);
      c1 = sink.ldat[15:0];
      wf(2); chk(cyc > 390 && cyc < 410, 1);
      chk(sink.ldat[15:0], c1 + 16'h0001);
   endtask : t_send
   task t_nack;
      slow <= 1'b1; ack <= 1'b0; wf(3);
      ack <= 1'b1; wf(4);
      rw(0, 8'h0C, 0); chk(q[3:2], 2'b01);
      rw(0, 8'h14, 0); chk(q, 32'h0000_0001);
      rw(1, 8'h1C, 32'h0000_0602); rw(1, 8'h00, 32'h0000_063D); wf(5);
      rw(0, 8'h0C, 0); chk(q[3], 1);
      chk(sink.ldat[15:0], {c1[7:0] + 8'h04, c1[15:8]});
   endtask : t_nack
   initial begin
      {rst, address, read, write, writedata, bus_activity, remote_line} = {1'b1, 44'h0};
      {off_condition, postproc_done, slow, ack, can_fw_version} = {4'b0001, 24'h01_0400};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_regs; t_wake; t_remote; t_cond; t_send; t_nack;
      end_sim;
   end
endmodule : can_wake_and_send_packer_tb_top
